// File: design/tbg_pkg.sv
// Purpose: shared constants for the three-wire burst power and gate enable block
// Assumes: core clock of 125 MHz
// Notes: period and timeout are kept in microseconds, cycle counts derive from them
package tbg_pkg;
  localparam int CLK_MHZ = 125;
  // burst period, fixed whatever the power setting
  localparam int BURST_PERIOD_US = 25;
  localparam int BURST_PERIOD_CYC = BURST_PERIOD_US * CLK_MHZ;
  // duty cycles are 2/15 .. 14/15 of the period
  localparam int DUTY_SLOTS = 15;
  localparam int DUTY_STEP = 2;
  // gate timeout after primary supply loss
  localparam int PD_TIMEOUT_US = 300;
  localparam int PD_TIMEOUT_CYC = PD_TIMEOUT_US * CLK_MHZ;
  // one-shot pulse width; plain default in core cycles
  localparam int ONE_SHOT_PULSE_CYC = 1250;
  // selector code width and legal range
  localparam int SEL_W = 4;
  localparam logic [2:0] SETTING_MIN = 3'h1;
  localparam logic [2:0] SETTING_MAX = 3'h7;
  // cycles after reset release before the straps are caught (one more than the synchroniser depth)
  localparam logic [1:0] STARTUP_CYC = 2'h3;
endpackage

// File: design/tbg_one_shot.sv
// Purpose: one-shot pulse on a qualified rising level
// Assumes: trig is synchronous to core_clk
// Notes: arms only after a low level has been seen
`timescale 1ns/100ps
module tbg_one_shot #(
  parameter int PULSE_CYC = tbg_pkg::ONE_SHOT_PULSE_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic trig,
  output logic pulse
);
  localparam int PW = $clog2(PULSE_CYC + 1);

  if (PULSE_CYC < 1) begin : g_bad_width
    $error("tbg_one_shot: pulse width must be at least one cycle");
  end

  logic armed;
  logic [PW-1:0] cnt;

  // starts disarmed, so a level high at power-up cannot fire
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 1'b0;
    end else if (!trig) begin
      armed <= 1'b1;
    end else if (armed) begin
      armed <= 1'b0;
    end
  end

  // pulse timer, ends on its own
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse <= 1'b0;
      cnt <= '0;
    end else if (armed && trig) begin
      pulse <= 1'b1;
      cnt <= PW'(1);
    end else if (pulse && cnt == PW'(PULSE_CYC)) begin
      pulse <= 1'b0;
      cnt <= '0;
    end else if (pulse) begin
      cnt <= cnt + PW'(1);
    end
  end

  a_pulse_armed: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(pulse) |-> $past(armed) && $past(trig))
    else $error("pulse fired without a seen low level");
  a_pulse_width: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(pulse) |-> $past(cnt) == PW'(PULSE_CYC))
    else $error("one-shot pulse width wrong");
  c_pulse_fire: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(pulse));
endmodule

// File: design/tbg_burst_gate.sv
// Purpose: burst power converter timing and gate enable for three-wire mode
// Assumes: rst_n is the power-up reset; pins arrive asynchronously
// Notes: straps and power setting are caught once after reset release
// Function
// - three-wire mode transfers power whenever primary rail present, ignoring enable
// - follow variant: gate output tracks enable level
// - after power-up, bursts of fixed 25 us period start at selected duty
// - bursts repeat continuously while primary rail present
// - period constant; on-time from seven settings, higher setting longer
// - duty cycles 13.3, 26.7, 40.0, 53.3, 66.7, 80.0, 93.3 percent
// - out-of-range selector falls back to the lowest duty cycle
// - power setting sampled once at power-up, held until power cycle
// - one-shot variant: rising enable gives a fixed-width gate pulse
// - host returns enable low first; device re-arms only after seeing low
// - one-shot variant uses the same power-up and burst sequence
// - gate answers enable only once secondary rails reach steady state
// - two- or three-wire mode chosen at power-up, kept until power cycle
// - either secondary rail undervoltage forces the gate low
// - primary loss with output on: gate forced low after 300 us timeout
`timescale 1ns/100ps
module tbg_burst_gate #(
  parameter int BURST_PERIOD_CYC = tbg_pkg::BURST_PERIOD_CYC,
  parameter int PULSE_CYC = tbg_pkg::ONE_SHOT_PULSE_CYC,
  parameter int PD_TIMEOUT_CYC = tbg_pkg::PD_TIMEOUT_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic primary_supply_rail,
  input wire logic enable_in,
  input wire logic [tbg_pkg::SEL_W-1:0] power_setting_select,
  input wire logic three_wire_strap,
  input wire logic one_shot_strap,
  input wire logic secondary_high_rail,
  input wire logic secondary_mid_rail,
  output logic burst_drive,
  output logic gate_drive_out,
  output logic rails_ready,
  output logic setup_done,
  output logic three_wire_mode,
  output logic one_shot_mode,
  output logic [2:0] power_setting
);
  localparam int CW = $clog2(BURST_PERIOD_CYC + 1);
  localparam int TW = $clog2(PD_TIMEOUT_CYC + 1);
  localparam int SW = tbg_pkg::SEL_W;
  localparam int NP = 5 + SW;

  // the shortest on-time must be at least one cycle
  if (BURST_PERIOD_CYC < tbg_pkg::DUTY_SLOTS || PD_TIMEOUT_CYC < 1) begin : g_bad_param
    $error("tbg_burst_gate: burst period or timeout too short");
  end
  if (SW < 3) begin : g_bad_sel
    $error("tbg_burst_gate: selector must be at least three bits");
  end

  // two-flop synchronisers for every pin
  logic [NP-1:0] pin_raw;
  logic [NP-1:0] pin_meta;
  logic [NP-1:0] pin_sync;
  assign pin_raw = {primary_supply_rail, enable_in, three_wire_strap, one_shot_strap,
                    secondary_high_rail & secondary_mid_rail, power_setting_select};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  logic rail_s;
  logic en_s;
  logic three_s;
  logic shot_s;
  logic sec_ok_s;
  logic [SW-1:0] sel_s;
  assign rail_s = pin_sync[NP-1];
  assign en_s = pin_sync[NP-2];
  assign three_s = pin_sync[NP-3];
  assign shot_s = pin_sync[NP-4];
  assign sec_ok_s = pin_sync[NP-5];
  assign sel_s = pin_sync[SW-1:0];

  // selector decode; codes outside 1..7 mean a resistor too large or too small
  logic sel_valid;
  logic [2:0] next_setting;
  always_comb begin
    sel_valid = sel_s >= SW'(tbg_pkg::SETTING_MIN) && sel_s <= SW'(tbg_pkg::SETTING_MAX);
    next_setting = sel_valid ? sel_s[2:0] : tbg_pkg::SETTING_MIN;
  end

  // startup wait lets the synchronisers fill before straps are caught
  logic [1:0] start_cnt;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_cnt <= '0;
    end else if (start_cnt != tbg_pkg::STARTUP_CYC) begin
      start_cnt <= start_cnt + 2'h1;
    end
  end

  // straps caught once; only a new power-up reset can change them
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      setup_done <= 1'b0;
      power_setting <= tbg_pkg::SETTING_MIN;
      three_wire_mode <= 1'b0;
      one_shot_mode <= 1'b0;
    end else if (!setup_done && start_cnt == tbg_pkg::STARTUP_CYC) begin
      setup_done <= 1'b1;
      power_setting <= next_setting;
      three_wire_mode <= three_s;
      one_shot_mode <= shot_s & three_s; // one-shot exists only in three-wire mode
    end
  end

  // on-time is 2*setting fifteenths of the fixed period
  logic [CW-1:0] on_limit;
  always_comb begin
    on_limit = CW'((BURST_PERIOD_CYC * tbg_pkg::DUTY_STEP * int'(power_setting))
                   / tbg_pkg::DUTY_SLOTS);
  end

  // converter runs with the rail; two-wire mode only while enable is high
  logic running;
  assign running = setup_done && rail_s && (three_wire_mode || en_s);

  // burst period counter; restarts at zero when the rail comes back
  logic [CW-1:0] per_cnt;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      per_cnt <= '0;
    end else if (!running) begin
      per_cnt <= '0;
    end else if (per_cnt == CW'(BURST_PERIOD_CYC - 1)) begin
      per_cnt <= '0;
    end else begin
      per_cnt <= per_cnt + CW'(1);
    end
  end

  // converter drive, high during the first on_limit cycles of each period
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_drive <= 1'b0;
    end else begin
      burst_drive <= running && (per_cnt < on_limit);
    end
  end

  // steady state: rails above threshold and a full burst already delivered
  logic burst_seen;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_seen <= 1'b0;
    end else if (running && per_cnt == CW'(BURST_PERIOD_CYC - 1)) begin
      burst_seen <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rails_ready <= 1'b0;
    end else begin
      rails_ready <= burst_seen && sec_ok_s;
    end
  end

  // one-shot path shares the synchronised enable
  logic shot_pulse;
  tbg_one_shot #(
    .PULSE_CYC(PULSE_CYC)
  ) u_one_shot (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .trig(en_s && one_shot_mode && rails_ready),
    .pulse(shot_pulse)
  );

  logic en_eff;
  assign en_eff = one_shot_mode ? shot_pulse : en_s;

  // timeout after primary loss; the secondary keeps its last state until then
  logic [TW-1:0] pd_cnt;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_cnt <= '0;
    end else if (rail_s || !setup_done) begin
      pd_cnt <= '0;
    end else if (pd_cnt != TW'(PD_TIMEOUT_CYC)) begin
      pd_cnt <= pd_cnt + TW'(1);
    end
  end

  // gate drive: undervoltage first, then supply loss, then enable
  logic next_gate;
  always_comb begin
    if (!setup_done || !sec_ok_s) begin
      next_gate = 1'b0;
    end else if (!rail_s) begin
      next_gate = (pd_cnt == TW'(PD_TIMEOUT_CYC)) ? 1'b0 : gate_drive_out;
    end else begin
      next_gate = en_eff && rails_ready;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_drive_out <= 1'b0;
    end else begin
      gate_drive_out <= next_gate;
    end
  end

  // helper: length of the current converter on-time
  logic [CW-1:0] on_len;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      on_len <= '0;
    end else begin
      on_len <= burst_drive ? on_len + CW'(1) : '0;
    end
  end

  // helper: cycles between burst starts, counted apart from the period counter
  logic burst_q;
  logic period_valid;
  logic [CW-1:0] since_rise;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_q <= 1'b0;
      since_rise <= '0;
    end else begin
      burst_q <= burst_drive;
      since_rise <= (burst_drive && !burst_q) ? CW'(1) : since_rise + CW'(1);
    end
  end

  // a rail dropout or a two-wire enable gap restarts the period, so only an unbroken run is judged
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      period_valid <= 1'b0;
    end else if (!running) begin
      period_valid <= 1'b0;
    end else if (burst_drive && !burst_q) begin
      period_valid <= 1'b1;
    end
  end

  // configuration caught once at power-up
  a_sel_fallback: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(setup_done) |-> power_setting == $past(next_setting))
    else $error("power setting not taken from decoded selector");
  a_sel_range: assert property (@(posedge core_clk) disable iff (!rst_n)
    setup_done |-> power_setting >= tbg_pkg::SETTING_MIN && power_setting <= tbg_pkg::SETTING_MAX)
    else $error("latched power setting out of range");
  a_setting_held: assert property (@(posedge core_clk) disable iff (!rst_n)
    setup_done && $past(setup_done) |-> $stable(power_setting) && $stable(three_wire_mode))
    else $error("strap value changed after power-up");
  a_mode_pair: assert property (@(posedge core_clk) disable iff (!rst_n)
    one_shot_mode |-> three_wire_mode)
    else $error("one-shot mode latched outside three-wire mode");

  // converter timing
  a_burst_start: assert property (@(posedge core_clk) disable iff (!rst_n)
    running && per_cnt == '0 |=> burst_drive)
    else $error("burst did not start at period begin");
  a_burst_length: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(burst_drive) && running && $past(running) |-> on_len == on_limit)
    else $error("burst on-time does not match setting");
  a_burst_period: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(burst_drive) && period_valid |-> since_rise == CW'(BURST_PERIOD_CYC))
    else $error("burst period not constant");
  a_three_wire_power: assert property (@(posedge core_clk) disable iff (!rst_n)
    setup_done && three_wire_mode && rail_s && !en_s && per_cnt == '0 |=> burst_drive)
    else $error("three-wire transfer depends on enable");
  a_two_wire_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
    setup_done && !three_wire_mode && !en_s |=> !burst_drive)
    else $error("two-wire converter runs with enable low");
  a_no_rail_burst: assert property (@(posedge core_clk) disable iff (!rst_n)
    !rail_s |=> !burst_drive)
    else $error("converter runs without primary rail");

  // gate path
  a_follow_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    setup_done && !one_shot_mode && rails_ready && rail_s && sec_ok_s
      |=> gate_drive_out == $past(en_s))
    else $error("gate does not follow enable");
  a_gate_before_setup: assert property (@(posedge core_clk) disable iff (!rst_n)
    !setup_done |=> !gate_drive_out)
    else $error("gate high before straps were caught");
  a_uv_gate_low: assert property (@(posedge core_clk) disable iff (!rst_n)
    !sec_ok_s |=> !gate_drive_out)
    else $error("gate high during secondary undervoltage");
  a_pd_timeout: assert property (@(posedge core_clk) disable iff (!rst_n)
    setup_done && !rail_s ##1 !rail_s && pd_cnt == TW'(PD_TIMEOUT_CYC) |=> !gate_drive_out)
    else $error("gate not forced low after supply loss timeout");
  a_pd_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    setup_done && sec_ok_s && !rail_s && pd_cnt != TW'(PD_TIMEOUT_CYC)
      |=> gate_drive_out == $past(gate_drive_out))
    else $error("gate changed before supply loss timeout");
  a_ready_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(gate_drive_out) |-> $past(rails_ready))
    else $error("gate rose before rails were ready");

  c_full_burst: cover property (@(posedge core_clk) disable iff (!rst_n)
    $fell(burst_drive) && running);
  c_two_wire_burst: cover property (@(posedge core_clk) disable iff (!rst_n)
    !three_wire_mode && $rose(burst_drive));
  c_gate_follow: cover property (@(posedge core_clk) disable iff (!rst_n)
    !one_shot_mode && $fell(gate_drive_out) && rail_s);
  c_pd_timeout: cover property (@(posedge core_clk) disable iff (!rst_n)
    !rail_s && $fell(gate_drive_out));
endmodule

// File: sim/tbg_host_model.sv
// Purpose: host logic that drives the enable pin
// Assumes: the pin changes just after the falling edge of core_clk
// Notes: a shot request gives a high level of hold cycles, then a low gap
`timescale 1ns/100ps
module tbg_host_model #(
  parameter int HOLD = 12
) (
  input wire logic core_clk,
  input wire logic want,
  input wire logic fire,
  output logic enable_in
);
  int cnt = 0;
  logic shot_hi = 1'b0;
  // a new shot is refused until the low gap has run out
  always @(negedge core_clk) begin
    if (fire && cnt == 0) begin
      shot_hi <= 1'b1;
      cnt <= HOLD + 3;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 4) shot_hi <= 1'b0; // low for at least 4 cycles before any new rise
    end
  end
  assign enable_in = want | shot_hi;
endmodule

// File: sim/tbg_burst_gate_tb_top.sv
// Purpose: self-checking bench for the burst power and gate enable block
// Assumes: short counts (period 30, pulse 5, timeout 50 cycles)
// Notes: inputs change at the falling edge; outputs sampled there too
`timescale 1ns/100ps
module tbg_burst_gate_tb_top;
  localparam int PER = 30;
  localparam int PW = 5;
  localparam int PD = 50;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic rail = 1'b1;
  logic [3:0] sel = 4'h1;
  logic tw = 1'b1;
  logic os = 1'b0;
  logic hi_ok = 1'b1;
  logic mid_ok = 1'b1;
  logic want = 1'b0;
  logic fire = 1'b0;
  logic en;
  logic burst, gate, ready, done, tw_m, os_m;
  logic [2:0] pset;
  int fails = 0;
  int n_compared = 0;
  int on_c, per_c, w;
  tbg_host_model u_host (.core_clk(core_clk), .want(want), .fire(fire), .enable_in(en));
  tbg_burst_gate #(.BURST_PERIOD_CYC(PER), .PULSE_CYC(PW), .PD_TIMEOUT_CYC(PD)) u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .primary_supply_rail(rail), .enable_in(en),
    .power_setting_select(sel), .three_wire_strap(tw), .one_shot_strap(os),
    .secondary_high_rail(hi_ok), .secondary_mid_rail(mid_ok), .burst_drive(burst),
    .gate_drive_out(gate), .rails_ready(ready), .setup_done(done),
    .three_wire_mode(tw_m), .one_shot_mode(os_m), .power_setting(pset));
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: %s seen %0d expected %0d", $time, what, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // power cycle: straps steady from reset until well after release
  task automatic power_up(input logic t, input logic o, input logic [3:0] s);
    rst_n = 1'b0;
    tw = t;
    os = o;
    sel = s;
    tick(12);
    rst_n = 1'b1;
    tick(6);
  endtask
  task automatic wait_ready();
    int k;
    k = 0;
    while (ready !== 1'b1 && k < 200) begin
      check(gate, 1'b0, "gate before ready");
      tick(1);
      k++;
    end
  endtask
  // on-time and period of one whole burst
  task automatic measure();
    int k;
    k = 0;
    while (burst !== 1'b0 && k < 100) begin tick(1); k++; end
    while (burst !== 1'b1 && k < 100) begin tick(1); k++; end
    on_c = 0;
    while (burst === 1'b1 && on_c < 100) begin tick(1); on_c++; end
    per_c = on_c;
    while (burst !== 1'b1 && per_c < 100) begin tick(1); per_c++; end
  endtask
  task automatic gate_width();
    int k;
    k = 0;
    w = 0;
    while (gate !== 1'b1 && k < 30) begin tick(1); k++; end
    while (gate === 1'b1 && w < 30) begin tick(1); w++; end
  endtask
  // all seven legal selector codes plus out-of-range codes 0, 8 and 15; enable held low throughout
  task automatic t_duty();
    logic [3:0] codes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hf};
    int s;
    foreach (codes[i]) begin
      s = (codes[i] >= 4'h1 && codes[i] <= 4'h7) ? int'(codes[i]) : 1;
      power_up(1'b1, 1'b0, codes[i]);
      sel = ~codes[i];
      check(tw_m, 1'b1, "three-wire latched");
      check(done, 1'b1, "setup done after power-up");
      measure();
      check(on_c, PER * 2 * s / 15, "on-time");
      check(per_c, PER, "period");
      measure();
      check(per_c, PER, "bursts keep running with enable low");
      check(pset, s[2:0], "setting held");
    end
    $display("duty test done");
  endtask
  task automatic t_follow();
    power_up(1'b1, 1'b0, 4'h3);
    want <= 1'b1;
    wait_ready();
    tick(4);
    check(gate, 1'b1, "gate follows high");
    want <= 1'b0;
    tick(4);
    check(gate, 1'b0, "gate follows low");
    want <= 1'b1;
    tick(4);
    mid_ok = 1'b0;
    tick(4);
    check(gate, 1'b0, "undervoltage holds gate low");
    check(ready, 1'b0, "not ready during undervoltage");
    measure();
    check(per_c, PER, "bursts during undervoltage");
    mid_ok = 1'b1;
    wait_ready();
    tick(4);
    hi_ok = 1'b0;
    tick(4);
    check(gate, 1'b0, "high rail undervoltage holds gate low");
    hi_ok = 1'b1;
    wait_ready();
    tick(4);
    rail = 1'b0;
    tick(5);
    check(burst, 1'b0, "no burst without rail");
    check(gate, 1'b1, "gate holds before timeout");
    tick(PD + 8);
    check(gate, 1'b0, "gate low after timeout");
    rail = 1'b1;
    want <= 1'b0;
    $display("follow test done");
  endtask
  task automatic t_one_shot();
    power_up(1'b1, 1'b1, 4'h2);
    check(os_m, 1'b1, "one-shot latched");
    measure();
    check(on_c, 8, "one-shot on-time");
    check(per_c, PER, "one-shot period");
    wait_ready();
    fire <= 1'b1;
    tick(1);
    fire <= 1'b0;
    gate_width();
    check(w, PW, "pulse width");
    tick(4);
    check(gate, 1'b0, "no pulse while enable stays high");
    tick(12);
    fire <= 1'b1;
    tick(1);
    fire <= 1'b0;
    gate_width();
    check(w, PW, "retrigger after low");
    $display("one-shot test done");
  endtask
  task automatic t_two_wire();
    int k;
    power_up(1'b0, 1'b1, 4'h7);
    check(tw_m, 1'b0, "two-wire latched");
    check(os_m, 1'b0, "one-shot needs three-wire");
    k = 0;
    repeat (2 * PER) begin
      if (burst === 1'b1) k++;
      tick(1);
    end
    check(k, 0, "two-wire idle with enable low");
    want <= 1'b1;
    measure();
    check(on_c, PER * 2 * 7 / 15, "two-wire on-time with enable high");
    check(per_c, PER, "two-wire period");
    tick(2);
    check(gate, 1'b1, "two-wire gate follows enable");
    check(tw_m, 1'b0, "two-wire kept");
    want <= 1'b0;
    $display("two-wire test done");
  endtask
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    t_duty();
    t_follow();
    t_one_shot();
    t_two_wire();
    report_and_stop();
  end
  // watchdog: the tests take under 3000 cycles
  initial begin
    #(8 * 20000);
    fails++;
    report_and_stop();
  end
endmodule
